//--- asr_params.svh
// constants of the angle sensor primary register bank
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ASR_OFS_RD_ADDR  6'h05
`define ASR_OFS_RD_STAT  6'h06
`define ASR_OFS_RD_MSB   6'h07
`define ASR_OFS_RD_LSB   6'h08
`define ASR_OFS_CH_A     6'h09
`define ASR_OFS_CH_B     6'h0A
`define ASR_OFS_CH_C     6'h0B
`define ASR_OFS_STATUS   6'h0C
`define ASR_OFS_CTRL     6'h0D
`define ASR_OFS_ANGLE    6'h0E
`define ASR_OFS_ERROR    6'h0F
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASR_BIT_EXR      15
`define ASR_BIT_RIP      8
`define ASR_BIT_RDN      0
`define ASR_BIT_FULL     3
`define ASR_BIT_SOFT     2
`define ASR_BIT_TCWE     1
`define ASR_BIT_TCR      0
`define ASR_BIT_BSY      13
`define ASR_BIT_SME      12
`define ASR_BIT_POR      9
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define ASR_ERR_RESET    16'h0200
`define ASR_CLK_NS       100
`define ASR_IRST_NS      1600
`define ASR_IRST_CYC     ((`ASR_IRST_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`endif

//--- asr_pkg.sv
// types of the angle sensor primary register bank
package asr_pkg;
    typedef enum logic [0:0] {
        ASR_IRST_IDLE = 1'b0,
        ASR_IRST_BUSY = 1'b1
    } asr_irst_e;

    typedef struct packed {
        logic [7:0]  rd_addr;
        logic [31:0] rd_data;
        logic        fetching;
        logic        fetch_done;
        logic        stat_wake;
        logic        stat_slew;
        logic        stat_abi;
        logic        stat_acd;
        logic        spin;
        logic [3:0]  ready_seen;
        logic        ang_ready;
        logic        tc_we;
        logic [15:0] err;
        logic [15:0] abi_pos;
        logic        counting;
        logic [15:0] prev_angle;
        logic [15:0] rdata;
        logic        full_pulse;
        logic        soft_pulse;
        logic        reload_pulse;
        logic        tcr_pulse;
        logic        tcr_val_p;
        logic        tcr_val_s;
        logic [15:0] snap_angle;
        logic [10:0] snap_tp;
        logic [10:0] snap_ts;
        asr_irst_e   irst;
        logic [4:0]  irst_cnt;
    } asr_state_s;
endpackage

//--- asr_regs.sv
// primary status, control, angle and error registers of the angle sensor
`timescale 1ns/1ps
`include "asr_params.svh"

module asr_regs (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             fetch_req,
    output logic      [7:0]  fetch_addr,
    input  wire logic        fetch_ack,
    input  wire logic [31:0] fetch_data,
    input  wire logic [15:0] hall_pair_one_value,
    input  wire logic [15:0] hall_pair_two_value,
    input  wire logic [15:0] hall_pair_three_value,
    input  wire logic        ecc_selftest_fail,
    input  wire logic        sleep_comparator_selftest_fail,
    input  wire logic        supply_ok_selftest_fail,
    input  wire logic [15:0] fault_mask,
    input  wire logic        woke_from_sleep,
    input  wire logic        slew_warning,
    input  wire logic        abi_integrity_error,
    input  wire logic [7:0]  slew_rate_limit,
    input  wire logic        slew_delay_enable,
    input  wire logic        encoder_commutation_outputs_on,
    input  wire logic        interp_skip,
    input  wire logic        direction_polarity_cfg,
    input  wire logic [15:0] main_angle,
    input  wire logic [3:0]  path_angle_valid,
    input  wire logic [15:0] diag_angle,
    input  wire logic [10:0] tally_primary,
    input  wire logic [10:0] tally_secondary,
    input  wire logic        turn_tally_write_done,
    input  wire logic        turn_tally_init_primary,
    input  wire logic        turn_tally_init_secondary,
    input  wire logic [15:0] fault_events,
    output logic             full_reset,
    output logic             soft_reset,
    output logic             eeprom_reload,
    output logic             turn_tally_write_enable,
    output logic             turn_tally_clear,
    output logic             turn_tally_preset_primary,
    output logic             turn_tally_preset_secondary,
    output logic      [15:0] abi_position,
    output logic             spin_direction,
    output logic             first_angle_ready,
    output logic      [15:0] diagnostic_angle_snapshot,
    output logic      [10:0] tally_latch_primary,
    output logic      [10:0] tally_latch_secondary
);
    import asr_pkg::*;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    asr_state_s  s;
    asr_state_s  next_s;
    logic [15:0] status_word;
    logic [15:0] delta;
    logic        wr_rd_stat;
    logic        wr_ctrl;
    logic        rd_status;
    logic        rd_error;
    logic        rd_angle;
    logic        slew_zero;
    logic [15:0] angle_step;

    assign wr_rd_stat = reg_wr && (reg_addr == `ASR_OFS_RD_STAT);
    assign wr_ctrl    = reg_wr && (reg_addr == `ASR_OFS_CTRL);
    assign rd_status  = reg_rd && (reg_addr == `ASR_OFS_STATUS);
    assign rd_error   = reg_rd && (reg_addr == `ASR_OFS_ERROR);
    assign rd_angle   = reg_rd && (reg_addr == `ASR_OFS_ANGLE);
    assign slew_zero  = (slew_rate_limit == 8'h00);
    assign delta      = main_angle - s.abi_pos;
    assign angle_step = main_angle - s.prev_angle;

    assign status_word = {6'h00, ecc_selftest_fail, sleep_comparator_selftest_fail,
                          supply_ok_selftest_fail, |fault_mask, s.stat_wake,
                          s.stat_slew, s.stat_abi, s.stat_acd, s.spin,
                          &s.ready_seen};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s              = s;
        next_s.full_pulse   = 1'b0;
        next_s.soft_pulse   = 1'b0;
        next_s.reload_pulse = 1'b0;
        next_s.tcr_pulse    = 1'b0;

        // read port; the word is taken before any clear-on-read
        if (reg_rd) begin
            if (reg_addr == `ASR_OFS_RD_ADDR) begin
                next_s.rdata = {8'h00, s.rd_addr};
            end else if (reg_addr == `ASR_OFS_RD_STAT) begin
                next_s.rdata = {7'h00, s.fetching, 7'h00, s.fetch_done};
            end else if (reg_addr == `ASR_OFS_RD_MSB) begin
                next_s.rdata = s.rd_data[31:16];
            end else if (reg_addr == `ASR_OFS_RD_LSB) begin
                next_s.rdata = s.rd_data[15:0];
            end else if (reg_addr == `ASR_OFS_CH_A) begin
                next_s.rdata = hall_pair_one_value;
            end else if (reg_addr == `ASR_OFS_CH_B) begin
                next_s.rdata = hall_pair_two_value;
            end else if (reg_addr == `ASR_OFS_CH_C) begin
                next_s.rdata = hall_pair_three_value;
            end else if (reg_addr == `ASR_OFS_STATUS) begin
                next_s.rdata = status_word;
            end else if (reg_addr == `ASR_OFS_CTRL) begin
                // only the enable is held; reset bits act and drop
                next_s.rdata = {14'h0000, s.tc_we, 1'b0};
            end else if (reg_addr == `ASR_OFS_ANGLE) begin
                // unsigned angle, 2^16 counts per turn
                next_s.rdata = main_angle;
            end else if (reg_addr == `ASR_OFS_ERROR) begin
                next_s.rdata = s.err;
            end else begin
                next_s.rdata = 16'h0000;
            end
        end

        // fetch address
        if (reg_wr && (reg_addr == `ASR_OFS_RD_ADDR)) begin
            next_s.rd_addr = reg_wdata[7:0];
        end

        if (s.fetching && fetch_ack) begin
            next_s.rd_data    = fetch_data;
            next_s.fetching   = 1'b0;
            next_s.fetch_done = 1'b1;
        end

        // execute starts a fetch; a second one while busy is an overflow
        if (wr_rd_stat && reg_wdata[`ASR_BIT_EXR]) begin
            if (s.fetching) begin
                next_s.err[`ASR_BIT_BSY] = 1'b1;
            end else begin
                next_s.fetching   = 1'b1;
                next_s.fetch_done = 1'b0;
            end
        end

        // sticky status, a new event beats the read clear
        if (rd_status) begin
            next_s.stat_wake = 1'b0;
            next_s.stat_slew = 1'b0;
            next_s.stat_abi  = 1'b0;
            next_s.stat_acd  = 1'b0;
        end
        if (woke_from_sleep) begin
            next_s.stat_wake = 1'b1;
        end
        if (slew_warning) begin
            next_s.stat_slew = 1'b1;
        end
        // integrity pulses count only at zero slew setting
        if (abi_integrity_error && slew_zero) begin
            next_s.stat_abi = 1'b1;
        end

        // count-up toward angle, shorter way round
        if (s.counting) begin
            if (slew_zero) begin
                next_s.abi_pos  = main_angle;
                next_s.counting = 1'b0;
            end else if (delta == 16'h0000) begin
                next_s.counting = 1'b0;
                if (!slew_delay_enable) begin
                    next_s.stat_acd = 1'b1;
                end
            end else if (delta[15]) begin
                next_s.abi_pos = s.abi_pos - 16'h0001;
            end else begin
                next_s.abi_pos = s.abi_pos + 16'h0001;
            end
        end else begin
            next_s.abi_pos = main_angle;
        end

        // direction only while outputs on or interpolator skipped
        next_s.prev_angle = main_angle;
        if (encoder_commutation_outputs_on || interp_skip) begin
            if (main_angle != s.prev_angle) begin
                next_s.spin = ~angle_step[15] ^ direction_polarity_cfg;
            end
        end else begin
            next_s.spin = 1'b0;
        end

        // each path seen ready at least once
        next_s.ready_seen = s.ready_seen | path_angle_valid;

        // angle read snapshots diagnostic angle and both tallies
        if (rd_angle) begin
            next_s.snap_angle = diag_angle;
            next_s.snap_tp    = tally_primary;
            next_s.snap_ts    = tally_secondary;
        end

        // latch, clear on read except shadow fault, keep a copy
        if (rd_error) begin
            next_s.rd_data[15:0] = s.err;
            next_s.err = s.err & (16'h0001 << `ASR_BIT_SME);
            // clearing faults restarts the count-up
            next_s.counting = 1'b1;
            next_s.abi_pos  = 16'h0000;
        end
        next_s.err = next_s.err | fault_events;

        // tally write enable, dropped once a write has happened
        if (turn_tally_write_done) begin
            next_s.tc_we = 1'b0;
        end
        if (wr_ctrl) begin
            next_s.tc_we = reg_wdata[`ASR_BIT_TCWE];
        end

        // clear both tallies to their own start values
        if (wr_ctrl && reg_wdata[`ASR_BIT_TCR]) begin
            next_s.tcr_pulse = 1'b1;
            next_s.tcr_val_p = turn_tally_init_primary;
            next_s.tcr_val_s = turn_tally_init_secondary;
        end

        // internal reset; the write enable is not cleared so the
        // enable and the tallies stay consistent across it
        if (wr_ctrl && (reg_wdata[`ASR_BIT_FULL] || reg_wdata[`ASR_BIT_SOFT])) begin
            next_s.irst         = ASR_IRST_BUSY;
            next_s.irst_cnt     = 5'(`ASR_IRST_CYC);
            next_s.full_pulse   = reg_wdata[`ASR_BIT_FULL];
            next_s.soft_pulse   = ~reg_wdata[`ASR_BIT_FULL];
            next_s.reload_pulse = reg_wdata[`ASR_BIT_FULL];
        end

        case (s.irst)
            ASR_IRST_IDLE: begin
            end
            ASR_IRST_BUSY: begin
                // status, error and processing held clear
                // access state lives outside and is not touched
                next_s.stat_wake  = 1'b0;
                next_s.stat_slew  = 1'b0;
                next_s.stat_abi   = 1'b0;
                next_s.stat_acd   = 1'b0;
                next_s.spin       = 1'b0;
                next_s.ready_seen = 4'h0;
                next_s.err        = 16'h0000;
                next_s.abi_pos    = 16'h0000;
                next_s.counting   = 1'b1;
                next_s.irst_cnt   = s.irst_cnt - 5'd1;
                if (s.irst_cnt == 5'd1) begin
                    // reset flag raised when reset ends
                    next_s.err[`ASR_BIT_POR] = 1'b1;
                    next_s.irst              = ASR_IRST_IDLE;
                end
            end
            default: begin
                next_s.irst = ASR_IRST_IDLE;
            end
        endcase

        // ready flag kept in its own flop so the output is registered
        next_s.ang_ready = &next_s.ready_seen;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            // power-on is a reset event
            s.err      <= `ASR_ERR_RESET;
            s.counting <= 1'b1;
            s.irst     <= ASR_IRST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata                   = s.rdata;
    assign fetch_req                   = s.fetching;
    assign fetch_addr                  = s.rd_addr;
    assign full_reset                  = s.full_pulse;
    assign soft_reset                  = s.soft_pulse;
    assign eeprom_reload               = s.reload_pulse;
    assign turn_tally_write_enable     = s.tc_we;
    assign turn_tally_clear            = s.tcr_pulse;
    assign turn_tally_preset_primary   = s.tcr_val_p;
    assign turn_tally_preset_secondary = s.tcr_val_s;
    assign abi_position                = s.abi_pos;
    assign spin_direction              = s.spin;
    assign first_angle_ready           = s.ang_ready;
    assign diagnostic_angle_snapshot   = s.snap_angle;
    assign tally_latch_primary         = s.snap_tp;
    assign tally_latch_secondary       = s.snap_ts;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_EXR_START: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_rd_stat && reg_wdata[15] && !s.fetching)
        |=> (fetch_req && !s.fetch_done))
        else $error("execute did not start a fetch");

    AST_FETCH_DONE: assert property (@(posedge ref_clk) disable iff (rst)
        (s.fetching && fetch_ack && !rd_error)
        |=> (s.fetch_done && s.rd_data[7:0] == $past(fetch_data[7:0])))
        else $error("fetched low byte not presented");

    AST_WAKE_RC: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_status && !woke_from_sleep) |=> !s.stat_wake)
        else $error("wake flag not cleared by status read");

    AST_ERR_COPY: assert property (@(posedge ref_clk) disable iff (rst)
        rd_error |=> (s.rd_data[15:0] == $past(s.err) && reg_rdata == $past(s.err)))
        else $error("error copy missing");

    AST_SME_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_error && s.err[12] && s.irst == ASR_IRST_IDLE && !wr_ctrl) |=> s.err[12])
        else $error("shadow fault cleared by read");

    AST_SNAPSHOT: assert property (@(posedge ref_clk) disable iff (rst)
        rd_angle |=> (diagnostic_angle_snapshot == $past(diag_angle)
                      && tally_latch_primary == $past(tally_primary)))
        else $error("angle read did not snapshot");

    AST_POR_AFTER: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && reg_wdata[3])
        |=> (full_reset && eeprom_reload) ##17 s.err[9])
        else $error("reset flag not raised after full reset");

    AST_TCWE_DROP: assert property (@(posedge ref_clk) disable iff (rst)
        (turn_tally_write_done && !wr_ctrl) |=> !turn_tally_write_enable)
        else $error("tally write enable not cleared");

    AST_SPIN_OFF: assert property (@(posedge ref_clk) disable iff (rst)
        (!encoder_commutation_outputs_on && !interp_skip) |=> !spin_direction)
        else $error("direction computed while disabled");

    AST_CTRL_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == `ASR_OFS_CTRL) |=> (reg_rdata[15:2] == 14'h0000))
        else $error("unused control bits not zero");
endmodule

//--- asr_fetch_mem.sv
// memory model answering the indirect read handshake of the register bank
`timescale 1ns/1ps
module asr_fetch_mem (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        fetch_req,
    input  wire logic [7:0]  fetch_addr,
    output logic             fetch_ack,
    output logic      [31:0] fetch_data
);
    int   age;
    logic held;
    // slow answers leave room to poke the bank while a fetch is still open
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fetch_ack  <= 1'b0;
            fetch_data <= 32'h5A5A_0FF0;
            age        <= 0;
            held       <= 1'b0;
        end else begin
            fetch_ack  <= 1'b0;
            // word means nothing outside the ack cycle, so it churns
            fetch_data <= ~fetch_data;
            age        <= fetch_req ? age + 1 : 0;
            held       <= fetch_req & held;
            if (fetch_req && !held && age >= (slow ? 12 : 1)) begin
                fetch_ack  <= 1'b1;
                fetch_data <= {fetch_addr, ~fetch_addr, fetch_addr ^ 8'h3C, fetch_addr + 8'h11};
                held       <= 1'b1;
            end
        end
    end
endmodule

//--- testbench.sv
// self-checking bench of the angle sensor primary register bank
`timescale 1ns/1ps
`include "asr_params.svh"
module testbench;
    logic        ref_clk, rst, reg_wr, reg_rd, fetch_req, fetch_ack, slow, first_angle_ready;
    logic        ecc_selftest_fail, sleep_comparator_selftest_fail, supply_ok_selftest_fail;
    logic        woke_from_sleep, slew_warning, abi_integrity_error, slew_delay_enable;
    logic        encoder_commutation_outputs_on, interp_skip, direction_polarity_cfg;
    logic        turn_tally_write_done, turn_tally_init_primary, turn_tally_init_secondary;
    logic        full_reset, soft_reset, eeprom_reload, turn_tally_write_enable, spin_direction;
    logic        turn_tally_clear, turn_tally_preset_primary, turn_tally_preset_secondary;
    logic [1:0]  pre;
    logic [3:0]  path_angle_valid;
    logic [5:0]  reg_addr;
    logic [7:0]  fetch_addr, slew_rate_limit, fa;
    logic [31:0] fetch_data;
    logic [15:0] reg_wdata, reg_rdata, fault_mask, main_angle, diag_angle, fault_events;
    logic [15:0] abi_position, diagnostic_angle_snapshot, hv[3];
    logic [15:0] hall_pair_one_value, hall_pair_two_value, hall_pair_three_value;
    logic [10:0] tally_primary, tally_secondary, tally_latch_primary, tally_latch_secondary;
    int          failures, n_tests, seed, err_m, np[4], lsb_q[$];

    assign hall_pair_one_value   = hv[0];
    assign hall_pair_two_value   = hv[1];
    assign hall_pair_three_value = hv[2];
    asr_regs      uut (.*);
    asr_fetch_mem mem (.*);

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // the run needs under two thousand cycles; twenty thousand is the cut-off
    initial begin
        #2000000;
        failures++;
        close_out;
    end
    always @(posedge ref_clk) begin
        np[0] += int'(full_reset === 1'b1);
        np[1] += int'(soft_reset === 1'b1);
        np[2] += int'(eeprom_reload === 1'b1);
        np[3] += int'(turn_tally_clear === 1'b1);
        if (turn_tally_clear === 1'b1) begin
            pre = {turn_tally_preset_primary, turn_tally_preset_secondary};
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] m, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk($sformatf("register %h", a), e & m, reg_rdata & m);
    endtask
    // model of the error word: read returns it, keeps only the shadow fault
    task automatic rd_err(input logic [15:0] m);
        rd(`ASR_OFS_ERROR, m, 16'(err_m));
        lsb_q.push_back(err_m);
        err_m &= 'h1000;
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 52;
        {reg_wr, reg_rd, reg_addr, reg_wdata, slow, fault_mask, fault_events} = '0;
        {ecc_selftest_fail, sleep_comparator_selftest_fail, supply_ok_selftest_fail} = '0;
        {woke_from_sleep, slew_warning, abi_integrity_error, slew_rate_limit} = '0;
        {slew_delay_enable, encoder_commutation_outputs_on, interp_skip} = '0;
        {direction_polarity_cfg, path_angle_valid, turn_tally_write_done} = '0;
        {turn_tally_init_primary, turn_tally_init_secondary, diag_angle} = '0;
        {main_angle, tally_primary, tally_secondary} = '0;
        rst = 1'b1;
        foreach (hv[i]) hv[i] = 16'($random(seed));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        err_m = `ASR_ERR_RESET;
        rd_err(16'hFFFF);
        rd(`ASR_OFS_RD_LSB, 16'hFFFF, 16'(lsb_q.pop_back()));
        @(posedge ref_clk);
        fault_events <= 16'h1011;
        @(posedge ref_clk);
        fault_events <= 16'h0000;
        err_m |= 'h1011;
        rd_err(16'hFFFF);
        rd_err(16'hFFFF);
        rd(`ASR_OFS_RD_LSB, 16'hFFFF, 16'(lsb_q.pop_back()));
        $display("end of error tests");
        for (int s = 0; s < 2; s++) begin
            fa = 8'($random(seed));
            slow <= s[0];
            bus(1'b1, `ASR_OFS_RD_ADDR, {8'h00, fa});
            bus(1'b1, `ASR_OFS_RD_STAT, 16'h8000);
            if (s == 1) begin
                rd(`ASR_OFS_RD_STAT, 16'hFFFF, 16'h0100);
                bus(1'b1, `ASR_OFS_RD_STAT, 16'h8000);
                err_m |= 'h2000;
                rd_err(16'hEFFF);
            end
            repeat (2) @(posedge ref_clk);
            for (int i = 0; i < 100 && fetch_req !== 1'b0; i++) @(posedge ref_clk);
            rd(`ASR_OFS_RD_STAT, 16'hFFFF, 16'h0001);
            rd(`ASR_OFS_RD_MSB, 16'hFFFF, {fa, ~fa});
            rd(`ASR_OFS_RD_LSB, 16'hFFFF, {fa ^ 8'h3C, fa + 8'h11});
        end
        rd(6'h3F, 16'hFFFF, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 6'(`ASR_OFS_CH_A + i), ~hv[i]);
            rd(6'(`ASR_OFS_CH_A + i), 16'hFFFF, hv[i]);
        end
        $display("end of fetch and channel tests");
        @(posedge ref_clk);
        {ecc_selftest_fail, sleep_comparator_selftest_fail, supply_ok_selftest_fail} <= 3'b101;
        fault_mask <= 16'h0040;
        {woke_from_sleep, slew_warning, abi_integrity_error} <= 3'b111;
        @(posedge ref_clk);
        {woke_from_sleep, slew_warning, abi_integrity_error} <= 3'b000;
        rd(`ASR_OFS_STATUS, 16'hFFF8, 16'h02F8);
        rd(`ASR_OFS_STATUS, 16'hFFF8, 16'h02C0);
        @(posedge ref_clk);
        {ecc_selftest_fail, sleep_comparator_selftest_fail, supply_ok_selftest_fail} <= 3'b010;
        fault_mask <= 16'h0000;
        slew_rate_limit <= 8'h04;
        {woke_from_sleep, slew_warning, abi_integrity_error} <= 3'b011;
        @(posedge ref_clk);
        {woke_from_sleep, slew_warning, abi_integrity_error} <= 3'b000;
        tally_primary <= 11'h2A5;
        tally_secondary <= 11'h2A5;
        rd(`ASR_OFS_STATUS, 16'hFFF8, 16'h0110);
        $display("end of status tests");
        bus(1'b1, `ASR_OFS_CTRL, 16'hFFF2);
        rd(`ASR_OFS_CTRL, 16'hFFFF, 16'h0002);
        chk("tally write enable", 16'h0001, {15'h0000, turn_tally_write_enable});
        @(posedge ref_clk);
        turn_tally_write_done <= 1'b1;
        @(posedge ref_clk);
        turn_tally_write_done <= 1'b0;
        {turn_tally_init_primary, turn_tally_init_secondary} <= 2'b10;
        rd(`ASR_OFS_CTRL, 16'hFFFF, 16'h0000);
        bus(1'b1, `ASR_OFS_CTRL, 16'h0001);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("tally clear", 16'h0006, {12'h000, 2'(np[3]), pre});
        @(posedge ref_clk);
        main_angle <= 16'($random(seed));
        diag_angle <= 16'($random(seed));
        tally_primary <= 11'($random(seed));
        tally_secondary <= 11'($random(seed));
        #1;
        rd(`ASR_OFS_ANGLE, 16'hFFFF, main_angle);
        chk("angle snapshot", diag_angle, diagnostic_angle_snapshot);
        chk("primary latch", 16'(tally_primary), 16'(tally_latch_primary));
        chk("secondary latch", 16'(tally_secondary), 16'(tally_latch_secondary));
        @(posedge ref_clk);
        main_angle <= main_angle + 16'h0100;
        repeat (3) @(posedge ref_clk);
        #1;
        chk("spin while off", 16'h0000, {15'h0000, spin_direction});
        @(posedge ref_clk);
        path_angle_valid <= 4'b0111;
        @(posedge ref_clk);
        path_angle_valid <= 4'b0000;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("ready early", 16'h0000, {15'h0000, first_angle_ready});
        @(posedge ref_clk);
        path_angle_valid <= 4'b1000;
        @(posedge ref_clk);
        path_angle_valid <= 4'b0000;
        rd(`ASR_OFS_STATUS, 16'h0001, 16'h0001);
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            direction_polarity_cfg <= k[0];
            encoder_commutation_outputs_on <= !k[1];
            interp_skip <= k[1];
            @(posedge ref_clk);
            main_angle <= main_angle + 16'h0100;
            repeat (3) @(posedge ref_clk);
            #1;
            chk("spin", {15'h0000, !k[0]}, {15'h0000, spin_direction});
        end
        @(posedge ref_clk);
        main_angle <= 16'hFFF0;
        for (int d = 0; d < 2; d++) begin
            @(posedge ref_clk);
            slew_delay_enable <= d[0];
            rd_err(16'hEFFF);
            repeat (40) @(posedge ref_clk);
            #1;
            chk("abi position", 16'hFFF0, abi_position);
            rd(`ASR_OFS_STATUS, 16'h0004, d ? 16'h0000 : 16'h0004);
            rd(`ASR_OFS_STATUS, 16'h0004, 16'h0000);
        end
        $display("end of angle tests");
        for (int r = 0; r < 2; r++) begin
            bus(1'b1, `ASR_OFS_CTRL, r ? 16'h0004 : 16'h0008);
            repeat (24) @(posedge ref_clk);
            #1;
            chk("reset pulses", {4'h1, 4'(r), 4'h1, 4'h0}, {4'(np[0]), 4'(np[1]), 4'(np[2]), 4'h0});
            err_m = 'h0200;
            rd_err(16'hEFFF);
            rd(`ASR_OFS_STATUS, 16'h0003, 16'h0000);
        end
        $display("end of reset tests");
        close_out;
    end
endmodule
